// >>> bench/host_model.sv
// Host model reading the status and data registers
`timescale 1ns/1ps
module host_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] converter_status,
  output logic            status_read,
  output logic            data_read_active,
  output logic            data_read_done
);
  initial begin
    status_read = 1'b0;
    data_read_active = 1'b0;
    data_read_done = 1'b0;
  end
  // Value taken before the clear side effect lands
  task read_status(output logic [7:0] v);
    @(negedge ref_clk);
    v = converter_status;
    status_read = 1'b1;
    @(negedge ref_clk);
    status_read = 1'b0;
  endtask
  // Long reads widen the window where a result is lost
  task read_data(input int hold);
    data_read_active = 1'b1;
    repeat (hold) @(negedge ref_clk);
    data_read_done = 1'b1;
    @(negedge ref_clk);
    data_read_done = 1'b0;
    data_read_active = 1'b0;
  endtask
endmodule

// >>> bench/test_adc_status_flags.sv
// Testbench for the converter status flag block
`timescale 1ns/1ps
module test_adc_status_flags;
  import adc_status_pkg::*;
  logic       ref_clk, reset, sync_n_pin, status_read, data_read_active, data_read_done;
  logic       result_write, result_dropped, fifo_error_summary, data_ready_n;
  logic [4:0] ev;
  logic [3:0] ch;
  logic [7:0] err, st, v, n_drop, cnt;
  int         n_fail, n_tests;
  adc_status_flags dut (
    .ref_clk(ref_clk), .reset(reset), .enter_idle(ev[0]), .cal_start(ev[1]),
    .conv_start(ev[2]), .result_pending(ev[3]), .result_channel(ch),
    .coef_write(ev[4]), .sync_n_pin(sync_n_pin), .data_read_active(data_read_active),
    .data_read_done(data_read_done), .status_read(status_read), .error_flags(err),
    .converter_status(st), .result_write(result_write),
    .result_dropped(result_dropped), .fifo_error_summary(fifo_error_summary),
    .data_ready_n(data_ready_n)
  );
  host_model host (
    .ref_clk(ref_clk), .converter_status(st), .status_read(status_read),
    .data_read_active(data_read_active), .data_read_done(data_read_done)
  );
  // ==========================================================
  // Helpers
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task pulse(input int k);
    ev[k] = 1'b1;
    @(negedge ref_clk);
    ev[k] = 1'b0;
  endtask
  task report_and_stop;
    if (n_fail == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
    if (reset) n_drop <= 8'h00;
    else if (result_dropped === 1'b1) n_drop <= n_drop + 8'h01;
  // Hang guard, far beyond the hundred or so cycles used
  initial begin
    #50us;
    n_fail++;
    report_and_stop;
  end
  // ==========================================================
  // Sequence
  initial begin
    reset = 1'b1;
    ev = 5'h00;
    ch = 4'h0;
    err = 8'h00;
    sync_n_pin = 1'b1;
    repeat (2) @(negedge ref_clk);
    reset = 1'b0;
    @(negedge ref_clk);
    chk(st, 8'h10);
    chk({7'h00, data_ready_n}, 8'h00);
    host.read_status(v);
    chk(v, 8'h10);
    @(negedge ref_clk);
    chk(st, 8'h00);
    ch = 4'hF;
    pulse(3);
    cnt = 8'h00;
    for (int i = 0; i < 10 && result_write !== 1'b1; i++) begin
      cnt = cnt + {7'h00, st[7]};
      @(negedge ref_clk);
    end
    chk(cnt, 8'(WARN_LEAD_CYCLES));
    chk(st, 8'h0F);
    sync_n_pin = 1'b0;
    repeat (6) @(negedge ref_clk);
    chk({7'h00, st[7]}, 8'h01);
    sync_n_pin = 1'b1;
    pulse(4);
    @(negedge ref_clk);
    chk({7'h00, st[7]}, 8'h00);
    host.read_data(2);
    @(negedge ref_clk);
    chk({7'h00, st[7]}, 8'h01);
    chk({7'h00, data_ready_n}, 8'h01);
    for (int k = 0; k < 3; k++) begin
      pulse(4);
      @(negedge ref_clk);
      pulse(k);
      @(negedge ref_clk);
      chk({7'h00, st[7]}, 8'h01);
    end
    for (int i = 0; i < 8; i++) begin
      err = 8'h01 << i;
      repeat (3) @(negedge ref_clk);
      chk({6'h00, st[6], fifo_error_summary}, 8'h03);
      err = 8'h00;
      repeat (3) @(negedge ref_clk);
      chk({6'h00, st[6], fifo_error_summary}, 8'h00);
    end
    ch = 4'h3;
    fork
      host.read_data(10);
      pulse(3);
    join
    repeat (4) @(negedge ref_clk);
    chk(n_drop, 8'h01);
    chk({4'h0, st[3:0]}, 8'h0F);
    pulse(3);
    repeat (8) @(negedge ref_clk);
    chk({4'h0, st[3:0]}, 8'h03);
    report_and_stop;
  end
endmodule

// >>> logic/adc_status_flags.sv
// Status register flag logic for the converter
`timescale 1ns/1ps
module adc_status_flags
  import adc_status_pkg::*;
#(
  parameter int ERR_WIDTH = 8
) (
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  input  wire logic                 enter_idle,
  input  wire logic                 cal_start,
  input  wire logic                 conv_start,
  input  wire logic                 result_pending,
  input  wire logic [CH_WIDTH-1:0]  result_channel,
  input  wire logic                 coef_write,
  input  wire logic                 sync_n_pin,
  input  wire logic                 data_read_active,
  input  wire logic                 data_read_done,
  input  wire logic                 status_read,
  input  wire logic [ERR_WIDTH-1:0] error_flags,
  output logic [7:0]                converter_status,
  output logic                      result_write,
  output logic                      result_dropped,
  output logic                      fifo_error_summary,
  output logic                      data_ready_n
);
  // ==========================================================
  // Sync pin
  logic sync_level;
  logic sync_prev;

  sync_pin_filter u_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .pin     (sync_n_pin),
    .level   (sync_level)
  );

  wire sync_fall = sync_prev && !sync_level;

  // ==========================================================
  // Result write scheduling
  logic                result_not_ready_flag;
  logic                error_summary;
  logic                por_flag;
  logic [CH_WIDTH-1:0] result_channel_index;
  logic [CH_WIDTH-1:0] pend_channel;
  logic [2:0]          lead_count;
  logic                lead_busy;
  logic                unread;
  logic                next_ready_n;
  logic                next_error_summary;
  logic                next_por;
  logic [CH_WIDTH-1:0] next_channel;
  logic [CH_WIDTH-1:0] next_pend_channel;
  logic [2:0]          next_lead_count;
  logic                next_lead_busy;
  logic                next_unread;
  logic                next_result_write;
  logic                next_dropped;

  always_comb begin
    next_ready_n       = result_not_ready_flag;
    next_error_summary = |error_flags;
    next_por           = por_flag;
    next_channel       = result_channel_index;
    next_pend_channel  = pend_channel;
    next_lead_count    = lead_count;
    next_lead_busy     = lead_busy;
    next_unread        = unread;
    next_result_write  = 1'b0;
    next_dropped       = 1'b0;
    // Lead counter holds the result back so the host is warned first
    if (result_pending && !lead_busy) begin
      next_lead_busy    = 1'b1;
      next_lead_count   = WARN_LEAD - 3'd1;
      next_pend_channel = result_channel;
      next_ready_n      = 1'b1;
    end else if (lead_busy) begin
      if (lead_count != 3'd0) begin
        next_lead_count = lead_count - 3'd1;
      end else begin
        next_lead_busy = 1'b0;
        if (data_read_active) begin
          next_dropped = 1'b1;
        end else begin
          next_result_write = 1'b1;
          next_channel      = pend_channel;
          next_ready_n      = 1'b0;
          next_unread       = 1'b1;
        end
      end
    end
    if (coef_write) begin
      next_ready_n = 1'b0;
    end
    if (data_read_done) begin
      next_ready_n = 1'b1;
      // A result landing as a read ends stays unread
      next_unread  = next_result_write;
    end
    if (sync_fall && unread) begin
      next_ready_n = 1'b1;
    end
    if (enter_idle || cal_start || conv_start) begin
      next_ready_n = 1'b1;
    end
    // Lead also outranks a coefficient write landing with the request
    if (lead_busy || next_lead_busy) begin
      next_ready_n = next_result_write ? 1'b0 : 1'b1;
    end
    if (status_read) begin
      next_por = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      result_not_ready_flag <= READY_N_RESET;
      error_summary         <= 1'b0;
      por_flag              <= POR_RESET;
      result_channel_index  <= CH_RESET;
      pend_channel          <= CH_RESET;
      lead_count            <= 3'd0;
      lead_busy             <= 1'b0;
      unread                <= 1'b0;
      result_write          <= 1'b0;
      result_dropped        <= 1'b0;
      sync_prev             <= 1'b1;
    end else begin
      result_not_ready_flag <= next_ready_n;
      error_summary         <= next_error_summary;
      por_flag              <= next_por;
      result_channel_index  <= next_channel;
      pend_channel          <= next_pend_channel;
      lead_count            <= next_lead_count;
      lead_busy             <= next_lead_busy;
      unread                <= next_unread;
      result_write          <= next_result_write;
      result_dropped        <= next_dropped;
      sync_prev             <= sync_level;
    end
  end

  // ==========================================================
  // Register image and pins
  always_comb begin
    converter_status                     = 8'h00;
    converter_status[READY_BIT]          = result_not_ready_flag;
    converter_status[ERR_BIT]            = error_summary;
    converter_status[RSVD_BIT]           = 1'b0;
    converter_status[POR_BIT]            = por_flag;
    converter_status[CH_WIDTH-1:0]       = result_channel_index;
  end

  assign fifo_error_summary = error_summary;
  assign data_ready_n       = result_not_ready_flag;

  // ==========================================================
  // Checks
  // Write and drop both follow the full four-cycle warning
  sequence warn_lead;
    result_not_ready_flag [*4];
  endsequence

  sequence write_or_drop;
    result_write ^ result_dropped;
  endsequence

  AST_LEAD_WARN: assert property (@(posedge ref_clk) disable iff (reset)
    (result_pending && !lead_busy) |=> warn_lead ##1 write_or_drop)
    else $error("result not resolved four cycles after warning");
  AST_WRITE_CLEARS: assert property (@(posedge ref_clk) disable iff (reset)
    result_write |-> !result_not_ready_flag)
    else $error("ready flag not cleared on result write");
  AST_DROP: assert property (@(posedge ref_clk) disable iff (reset)
    result_dropped |-> !result_write && $stable(result_channel_index))
    else $error("dropped result still written");
  AST_ERR_SUM: assert property (@(posedge ref_clk) disable iff (reset)
    ##1 (error_summary == |$past(error_flags)))
    else $error("error summary mismatch");
  AST_ERR_CLEAR: assert property (@(posedge ref_clk) disable iff (reset)
    (error_flags == '0) [*2] |-> !error_summary)
    else $error("error summary did not self clear");
  AST_FIFO_ERR: assert property (@(posedge ref_clk) disable iff (reset)
    error_summary |-> fifo_error_summary)
    else $error("fifo error bit not mirrored");
  AST_POR_CLR: assert property (@(posedge ref_clk) disable iff (reset)
    status_read |=> !por_flag [*1])
    else $error("power-on flag not cleared by read");
  AST_START_SETS: assert property (@(posedge ref_clk) disable iff (reset)
    (enter_idle || cal_start || conv_start) |=> result_not_ready_flag || result_write)
    else $error("ready flag not set on start or idle");
  AST_READ_SETS: assert property (@(posedge ref_clk) disable iff (reset)
    (data_read_done && !lead_busy) |=> result_not_ready_flag)
    else $error("data read did not set ready flag");
  AST_PIN: assert property (@(posedge ref_clk) disable iff (reset)
    data_ready_n == converter_status[READY_BIT])
    else $error("data ready pin differs from flag");
  AST_CHAN: assert property (@(posedge ref_clk) disable iff (reset)
    result_write |-> result_channel_index == $past(pend_channel))
    else $error("channel index not updated with result");
  AST_SYNC_SETS: assert property (@(posedge ref_clk) disable iff (reset)
    (sync_fall && unread && !lead_busy) |=> result_not_ready_flag)
    else $error("sync fall with unread result did not set ready flag");
  AST_COEF_CLEARS: assert property (@(posedge ref_clk) disable iff (reset)
    (coef_write && !lead_busy && !result_pending && !data_read_done && !sync_fall
      && !enter_idle && !cal_start && !conv_start) |=> !result_not_ready_flag)
    else $error("coefficient write did not clear ready flag");
  AST_ERR_SET: assert property (@(posedge ref_clk) disable iff (reset)
    (error_flags != '0) |=> error_summary)
    else $error("error summary not set by error flag");
  AST_POR_KEEP: assert property (@(posedge ref_clk) disable iff (reset)
    (por_flag && !status_read) |=> por_flag)
    else $error("power-on flag lost without status read");
  AST_LAYOUT: assert property (@(posedge ref_clk) disable iff (reset)
    converter_status == {result_not_ready_flag, error_summary, 1'b0, por_flag,
                         result_channel_index})
    else $error("status register layout wrong");
  AST_UNREAD_WRITE: assert property (@(posedge ref_clk) disable iff (reset)
    result_write |-> unread)
    else $error("written result not marked unread");
  AST_CHAN_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
    !result_write |-> $stable(result_channel_index))
    else $error("channel index changed without a result write");
  AST_DROP_FLAG: assert property (@(posedge ref_clk) disable iff (reset)
    result_dropped |-> result_not_ready_flag)
    else $error("ready flag cleared by a dropped result");
endmodule

// >>> logic/adc_status_pkg.sv
// Constants for the converter status flag block
// Behaviour
// - Idle, calibration or conversion start sets ready_n
// - Sync falling edge with unread result sets ready_n
// - Ready_n rises four clocks before result write
// - Result arriving during data read is dropped
// - Error summary is OR of error flags
// - Error summary mirrored to FIFO status bit
// - Error summary clears itself when errors clear
// - Power-on flag reads one after reset
// - Status register read clears power-on flag
// - Four-bit field shows channel of held result
// - Channel field is binary setup slot index
// - Result or coefficient write clears ready_n
// - Data-ready pin low while ready_n is zero
// - Data read sets ready_n; coefficient reads don't
package adc_status_pkg;
  // ==========================================================
  // Register layout
  localparam logic [7:0] STATUS_OFFSET     = 8'h00;
  localparam int         READY_BIT         = 7;
  localparam int         ERR_BIT           = 6;
  localparam int         RSVD_BIT          = 5;
  localparam int         POR_BIT           = 4;
  localparam int         CH_WIDTH          = 4;
  localparam logic       READY_N_RESET     = 1'b0;
  localparam logic       POR_RESET         = 1'b1;
  localparam logic [3:0] CH_RESET          = 4'h0;
  // ==========================================================
  // Timing
  localparam int         WARN_LEAD_CYCLES  = 4;
  localparam logic [2:0] WARN_LEAD         = 3'(WARN_LEAD_CYCLES);
endpackage

// >>> logic/sync_pin_filter.sv
// Three-stage synchroniser for an external pin
`timescale 1ns/1ps
module sync_pin_filter (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic pin,
  output logic      level
);
  logic s1;
  logic s2;
  logic s3;
  logic next_level;

  always_comb begin
    next_level = level;
    // Change counts only once two later stages agree
    if (s2 == s3) begin
      next_level = s2;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s1    <= 1'b1;
      s2    <= 1'b1;
      s3    <= 1'b1;
      level <= 1'b1;
    end else begin
      s1    <= pin;
      s2    <= s1;
      s3    <= s2;
      level <= next_level;
    end
  end
endmodule
